/* File: t1ec_host_model.sv */
// host processor model that drives the parallel register port
`timescale 1ns/10ps
`default_nettype none
module t1ec_host_model (
  input  wire logic       clk_sys,
  output logic            hostSel,
  output logic            hostWr,
  output logic            hostRd,
  output logic [7:0]      hostAddr,
  output logic [7:0]      hostWrData,
  input  wire logic [7:0] hostRdData
);
  import t1ec_pkg::*;
  logic fastAccess;  // host copy of the clock-double setting

  // idle port at time zero
  initial begin
    hostSel    = 1'b0;
    hostWr     = 1'b0;
    hostRd     = 1'b0;
    hostAddr   = 8'h00;
    hostWrData = 8'h00;
    fastAccess = 1'b0;
  end

  // gap after each access: 7 cycles cover 160ns, 4 cover 80ns
  task automatic spacing;
    repeat (fastAccess ? 4 : 7) @(posedge clk_sys);
  endtask : spacing

  // one write; released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] dd;
    dd = (a == ADDR_RST_CTL) ? (d & 8'hFD) : d;
    @(posedge clk_sys);
    hostSel    <= 1'b1;
    hostWr     <= 1'b1;
    hostAddr   <= a;
    hostWrData <= dd;
    @(posedge clk_sys);
    hostSel    <= 1'b0;
    hostWr     <= 1'b0;
    hostAddr   <= ~a;
    hostWrData <= ~dd;
    spacing();
    // old spacing kept until the new clock rate is surely in force
    if (a == ADDR_RST_CTL) begin
      fastAccess = dd[RC_DBL] & ~dd[RC_RST];
    end
  endtask : wr

  // one read; data is taken one edge after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    hostSel  <= 1'b1;
    hostRd   <= 1'b1;
    hostAddr <= a;
    @(posedge clk_sys);
    hostSel  <= 1'b0;
    hostRd   <= 1'b0;
    hostAddr <= ~a;
    @(posedge clk_sys);
    #1;
    d = hostRdData;
    spacing();
  endtask : rd
endmodule : t1ec_host_model
`default_nettype wire

/* File: t1ec_pkg.sv */
// shared constants and carrier types for the T1 error insert / reset / mask block
package t1ec_pkg;
  // register offsets on the parallel port
  localparam logic [7:0] ADDR_ERR_INS  = 8'h19;
  localparam logic [7:0] ADDR_RST_CTL  = 8'h1A;
  localparam logic [7:0] ADDR_INT_MSK0 = 8'h1B;
  localparam logic [7:0] REG_RST_VAL   = 8'h00;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;
  // error insertion field positions
  localparam int EI_BPV = 7;
  localparam int EI_CRC = 6;
  localparam int EI_FT  = 5;
  localparam int EI_FS  = 4;
  localparam int EI_ZRO = 3;
  localparam int EI_PAY = 2;
  localparam int EI_L32 = 1;
  localparam int EI_SEL = 0;
  // reset and counter control field positions
  localparam int RC_RST = 7;
  localparam int RC_SPN = 6;
  localparam int RC_ACK = 5;
  localparam int RC_CLR = 4;
  localparam int RC_SMP = 3;
  localparam int RC_OOF = 2;
  localparam int RC_RSV = 1;
  localparam int RC_DBL = 0;
  // interrupt mask zero field positions
  localparam int IM_TFS = 7;
  localparam int IM_MFS = 6;
  localparam int IM_BOM = 5;
  localparam int IM_AIS = 4;
  localparam int IM_LOS = 3;
  localparam int IM_SEF = 2;
  localparam int IM_TXS = 1;
  localparam int IM_RXS = 0;
  // zero run thresholds, step and clear value for digital loss of signal
  localparam logic [7:0] ZRUN_SHORT = 8'h20;
  localparam logic [7:0] ZRUN_LONG  = 8'hC0;
  localparam logic [7:0] ZRUN_ONE   = 8'h01;
  localparam logic [7:0] ZRUN_ZERO  = 8'h00;

  // one-cycle injection requests toward the transmit framer
  typedef struct packed {
    logic bipolarFaultInject;
    logic checkSumFaultInject;
    logic terminalFramingFaultInject;
    logic signallingFramingFaultInject;
    logic payloadFaultInject;
  } t1ec_inj_t;

  // framer status levels and event pulses feeding the interrupt logic
  typedef struct packed {
    logic terminalSyncLoss;
    logic multiframeSyncLoss;
    logic bitOrientedMessage;
    logic allOnesAlarm;
    logic severeFramingEvt;
    logic transmitSlipEvt;
    logic receiveSlipEvt;
  } t1ec_evt_t;
endpackage : t1ec_pkg

/* File: t1ec_regs.sv */
// control registers for error insertion, reset/counter control and interrupt mask zero
// Behaviour
// [RL1] rising edge of error bit 7 inserts exactly one bipolar violation
// [RL2] rising edge of bit 6 corrupts one transmitted CRC-6 in extended superframe
// [RL3] rising edge of bit 5 inserts one terminal or ESF framing error
// [RL4] rising edge of bit 4 inserts one signalling framing error, superframe only
// [RL5] bit 3 high forces all-zero transmit, overriding zero code suppression
// [RL6] rising edge of bit 2 flips one payload bit
// [RL7] loss of signal after 32 zeros if select high, else 192
// [RL8] bit 0 picks indicator pin source: signal loss only, or with frame loss
// [RL9] reset bit acts as full reset of defaults and counters, then self-clears
// [RL10] suspend bit floats interrupt output and ignores all interrupts
// [RL11] acknowledge bit clears pending interrupts, floats output, then self-clears
// [RL12] counter clear bit holds all status error counters at zero
// [RL13] sample bit lets error counters update only on one-second ticks
// [RL14] pause bit stops violation counter while out of frame
// [RL15] host keeps reserved bit 1 of reset control at zero
// [RL16] bit 0 doubles controller clock, halving host access spacing
// [RL17] each mask bit one lets its event interrupt, zero blocks it
// [RL18] changes of terminal or multiframe sync loss interrupt when unmasked
// [RL19] bit-oriented message arrival or end interrupts when unmasked
// [RL20] changes of all-ones alarm or loss of signal interrupt when unmasked
// [RL21] two framing errors in six bits interrupt when unmasked
// [RL22] transmit and receive controlled slips interrupt when unmasked
// [RL23] interrupt output low while unmasked interrupt pending and not suspended
`timescale 1ns/10ps
`default_nettype none
module t1ec_regs (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic                hostSel,
  input  wire logic                hostWr,
  input  wire logic                hostRd,
  input  wire logic [7:0]          hostAddr,
  input  wire logic [7:0]          hostWrData,
  output logic      [7:0]          hostRdData,
  input  wire t1ec_pkg::t1ec_evt_t evtIn,
  input  wire logic                esfMode,
  input  wire logic                rxBitValid,
  input  wire logic                rxBit,
  input  wire logic                oneSecondTick,
  output t1ec_pkg::t1ec_inj_t      injectPulse,
  output logic                     forceAllZeroTransmit,
  output logic                     lineSignalAbsentStatus,
  output logic                     signalAbsentIndicatorPin,
  output logic                     counterClearHold,
  output logic                     counterUpdateEnable,
  output logic                     violationCountEnable,
  output logic                     controllerClockDouble,
  output logic                     irqOutB,
  output logic                     irqOe
);
  import t1ec_pkg::*;

  // one decoder shared by read and write paths
  function automatic logic regHit(input logic [7:0] a, input logic [7:0] o);
    regHit = (a == o);
  endfunction : regHit

  logic [7:0] errIns_q, errIns_d, errPrev_q, errPrev_d;
  logic [7:0] rstCtl_q, rstCtl_d, mask_q, mask_d;
  logic [7:0] rdData_q, rdData_d;
  logic       swRst_q, swRst_d, ack_q, ack_d;
  t1ec_inj_t  inj_q, inj_d;
  logic       wrStb, rdStb;

  assign wrStb = hostSel & hostWr;
  assign rdStb = hostSel & hostRd;

  // host register file; reset and acknowledge are held one cycle then drop
  always_comb begin
    errIns_d  = errIns_q;
    rstCtl_d  = rstCtl_q;
    mask_d    = mask_q;
    rdData_d  = rdData_q;
    swRst_d   = 1'b0;
    ack_d     = 1'b0;
    errPrev_d = errIns_q;
    if (wrStb && regHit(hostAddr, ADDR_ERR_INS)) begin
      errIns_d = hostWrData;
    end
    if (wrStb && regHit(hostAddr, ADDR_RST_CTL)) begin
      rstCtl_d         = hostWrData;
      rstCtl_d[RC_RSV] = 1'b0; // RL15
      rstCtl_d[RC_RST] = 1'b0;
      rstCtl_d[RC_ACK] = 1'b0;
      swRst_d          = hostWrData[RC_RST]; // RL9
      ack_d            = hostWrData[RC_ACK]; // RL11
    end
    if (wrStb && regHit(hostAddr, ADDR_INT_MSK0)) begin
      mask_d = hostWrData; // RL17
    end
    if (rdStb) begin
      if (regHit(hostAddr, ADDR_ERR_INS)) begin
        rdData_d = errIns_q;
      end else if (regHit(hostAddr, ADDR_RST_CTL)) begin
        rdData_d = rstCtl_q;
        rdData_d[RC_RST] = swRst_q;
        rdData_d[RC_ACK] = ack_q;
      end else if (regHit(hostAddr, ADDR_INT_MSK0)) begin
        rdData_d = mask_q;
      end else begin
        rdData_d = RD_UNMAPPED;
      end
    end
    // edge detect; the prior value is held, so one rising edge gives one pulse
    inj_d.bipolarFaultInject   = errIns_q[EI_BPV] & ~errPrev_q[EI_BPV]; // RL1
    inj_d.checkSumFaultInject  = errIns_q[EI_CRC] & ~errPrev_q[EI_CRC] & esfMode; // RL2
    inj_d.terminalFramingFaultInject = errIns_q[EI_FT] & ~errPrev_q[EI_FT]; // RL3
    inj_d.signallingFramingFaultInject =
      errIns_q[EI_FS] & ~errPrev_q[EI_FS] & ~esfMode; // RL4
    inj_d.payloadFaultInject   = errIns_q[EI_PAY] & ~errPrev_q[EI_PAY]; // RL6
    // software reset overrides every host write in the same cycle
    if (swRst_q) begin
      errIns_d  = REG_RST_VAL; // RL9
      rstCtl_d  = REG_RST_VAL;
      mask_d    = REG_RST_VAL;
      errPrev_d = REG_RST_VAL;
      swRst_d   = 1'b0;
      ack_d     = 1'b0;
    end
  end

  // host register flip-flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      errIns_q  <= REG_RST_VAL;
      errPrev_q <= REG_RST_VAL;
      rstCtl_q  <= REG_RST_VAL;
      mask_q    <= REG_RST_VAL;
      rdData_q  <= RD_UNMAPPED;
      swRst_q   <= 1'b0;
      ack_q     <= 1'b0;
      inj_q     <= '0;
    end else begin
      errIns_q  <= errIns_d;
      errPrev_q <= errPrev_d;
      rstCtl_q  <= rstCtl_d;
      mask_q    <= mask_d;
      rdData_q  <= rdData_d;
      swRst_q   <= swRst_d;
      ack_q     <= ack_d;
      inj_q     <= inj_d;
    end
  end

  logic [7:0] zeroRun_q, zeroRun_d, pend_q, pend_d, evtVec;
  logic       tfsPrev_q, mfsPrev_q, bomPrev_q, aisPrev_q, losPrev_q;
  logic       los_d, los_q, pin_d, pin_q, clr_d, clr_q, upd_d, upd_q;
  logic       lcv_d, lcv_q, oe_d, oe_q, zro_q, dbl_q;
  logic [7:0] zeroThr;

  // shorter threshold trades false alarms for faster detection
  assign zeroThr = errIns_q[EI_L32] ? ZRUN_SHORT : ZRUN_LONG; // RL7

  // line status, counter controls and interrupt pending bits
  always_comb begin
    zeroRun_d = zeroRun_q;
    if (swRst_q) begin
      zeroRun_d = ZRUN_ZERO;
    end else if (rxBitValid) begin
      if (rxBit) begin
        zeroRun_d = ZRUN_ZERO;
      end else if (zeroRun_q < ZRUN_LONG) begin
        zeroRun_d = zeroRun_q + ZRUN_ONE; // saturates at the long threshold
      end
    end
    los_d = (zeroRun_d >= zeroThr); // RL7
    pin_d = errIns_q[EI_SEL] ? los_q : (los_q | evtIn.terminalSyncLoss); // RL8
    clr_d = rstCtl_q[RC_CLR] | swRst_q; // RL12
    upd_d = ~rstCtl_q[RC_SMP] | oneSecondTick; // RL13
    lcv_d = ~(rstCtl_q[RC_OOF] & evtIn.terminalSyncLoss); // RL14
    evtVec[IM_TFS] = evtIn.terminalSyncLoss ^ tfsPrev_q; // RL18
    evtVec[IM_MFS] = evtIn.multiframeSyncLoss ^ mfsPrev_q; // RL18
    evtVec[IM_BOM] = evtIn.bitOrientedMessage ^ bomPrev_q; // RL19
    evtVec[IM_AIS] = evtIn.allOnesAlarm ^ aisPrev_q; // RL20
    evtVec[IM_LOS] = los_q ^ losPrev_q; // RL20
    evtVec[IM_SEF] = evtIn.severeFramingEvt; // RL21
    evtVec[IM_TXS] = evtIn.transmitSlipEvt; // RL22
    evtVec[IM_RXS] = evtIn.receiveSlipEvt; // RL22
    pend_d = pend_q;
    if (ack_q || swRst_q) begin
      pend_d = '0; // RL11
    end
    // a new event in the acknowledge cycle beats the clear and is kept; one in the write cycle before it is cleared
    // soft reset drops events too, so no request survives it
    if (!rstCtl_q[RC_SPN] && !swRst_q) begin
      pend_d = pend_d | (evtVec & mask_q); // RL17
    end
    oe_d = (|pend_d) & ~rstCtl_d[RC_SPN] & ~ack_d; // RL23
  end

  // status flip-flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      zeroRun_q <= ZRUN_ZERO;
      pend_q    <= '0;
      tfsPrev_q <= 1'b0;
      mfsPrev_q <= 1'b0;
      bomPrev_q <= 1'b0;
      aisPrev_q <= 1'b0;
      losPrev_q <= 1'b0;
      los_q     <= 1'b0;
      pin_q     <= 1'b0;
      clr_q     <= 1'b0;
      upd_q     <= 1'b1;
      lcv_q     <= 1'b1;
      oe_q      <= 1'b0;
      zro_q     <= 1'b0;
      dbl_q     <= 1'b0;
    end else begin
      zeroRun_q <= zeroRun_d;
      pend_q    <= pend_d;
      tfsPrev_q <= evtIn.terminalSyncLoss;
      mfsPrev_q <= evtIn.multiframeSyncLoss;
      bomPrev_q <= evtIn.bitOrientedMessage;
      aisPrev_q <= evtIn.allOnesAlarm;
      losPrev_q <= los_q;
      los_q     <= los_d;
      pin_q     <= pin_d;
      clr_q     <= clr_d;
      upd_q     <= upd_d;
      lcv_q     <= lcv_d;
      oe_q      <= oe_d; // RL10
      zro_q     <= errIns_d[EI_ZRO]; // RL5
      dbl_q     <= rstCtl_d[RC_DBL]; // RL16
    end
  end

  // outputs straight from flip-flops, save the open-drain pin, tied low so it only ever pulls low
  assign hostRdData               = rdData_q;
  assign injectPulse              = inj_q;
  assign forceAllZeroTransmit     = zro_q;
  assign lineSignalAbsentStatus   = los_q;
  assign signalAbsentIndicatorPin = pin_q;
  assign counterClearHold         = clr_q;
  assign counterUpdateEnable      = upd_q;
  assign violationCountEnable     = lcv_q;
  assign controllerClockDouble    = dbl_q;
  assign irqOutB                  = 1'b0;
  assign irqOe                    = oe_q;

  // checks
  sequence s_rstWrite;
    wrStb && regHit(hostAddr, ADDR_RST_CTL) && hostWrData[RC_RST];
  endsequence
  sequence s_rstDone;
    swRst_q ##1 (!swRst_q && errIns_q == REG_RST_VAL && mask_q == REG_RST_VAL
      && counterClearHold && !irqOe);
  endsequence
  property p_bpvOnce;
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(errIns_q[EI_BPV]) |=> inj_q.bipolarFaultInject ##1 !inj_q.bipolarFaultInject;
  endproperty
  a_bpvOnce: assert property (p_bpvOnce) else $error("bipolar pulse wrong"); // RL1
  property p_fsMode;
    @(posedge clk_sys) disable iff (!rst_b)
    inj_q.signallingFramingFaultInject |-> !$past(esfMode);
  endproperty
  a_fsMode: assert property (p_fsMode) else $error("fs inject in esf"); // RL4
  property p_zeroTx;
    @(posedge clk_sys) disable iff (!rst_b)
    (wrStb && regHit(hostAddr, ADDR_ERR_INS) && !swRst_q)
      |=> forceAllZeroTransmit == $past(hostWrData[EI_ZRO]);
  endproperty
  a_zeroTx: assert property (p_zeroTx) else $error("all zero level wrong"); // RL5
  property p_losThr;
    @(posedge clk_sys) disable iff (!rst_b)
    lineSignalAbsentStatus |-> zeroRun_q >= $past(zeroThr);
  endproperty
  a_losThr: assert property (p_losThr) else $error("los below threshold"); // RL7
  property p_swRst;
    @(posedge clk_sys) disable iff (!rst_b)
    s_rstWrite |=> s_rstDone;
  endproperty
  a_swRst: assert property (p_swRst) else $error("soft reset not done"); // RL9
  property p_suspend;
    @(posedge clk_sys) disable iff (!rst_b)
    rstCtl_q[RC_SPN] |-> !irqOe;
  endproperty
  a_suspend: assert property (p_suspend) else $error("irq while suspended"); // RL10
  property p_ack;
    @(posedge clk_sys) disable iff (!rst_b)
    (wrStb && regHit(hostAddr, ADDR_RST_CTL) && hostWrData[RC_ACK] && !swRst_q)
      |=> !irqOe ##1 !ack_q;
  endproperty
  a_ack: assert property (p_ack) else $error("ack did not float irq"); // RL11
  property p_mask;
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(pend_q[IM_RXS]) |-> $past(mask_q[IM_RXS]) && $past(evtIn.receiveSlipEvt);
  endproperty
  a_mask: assert property (p_mask) else $error("masked slip pending"); // RL17
  property p_sample;
    @(posedge clk_sys) disable iff (!rst_b)
    ($past(rstCtl_q[RC_SMP]) && counterUpdateEnable) |-> $past(oneSecondTick);
  endproperty
  a_sample: assert property (p_sample) else $error("update off tick"); // RL13
  property p_irq;
    @(posedge clk_sys) disable iff (!rst_b)
    (|pend_q && !rstCtl_q[RC_SPN] && !ack_q && !swRst_q && !ack_d) |-> irqOe;
  endproperty
  a_irq: assert property (p_irq) else $error("pending irq not driven"); // RL23
  property p_crcEsf;
    @(posedge clk_sys) disable iff (!rst_b)
    inj_q.checkSumFaultInject
      |-> $past(esfMode) && $past(errIns_q[EI_CRC]) && !$past(errPrev_q[EI_CRC]);
  endproperty
  a_crcEsf: assert property (p_crcEsf) else $error("crc inject without esf edge"); // RL2
  property p_ftOnce;
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(errIns_q[EI_FT]) |=> inj_q.terminalFramingFaultInject
      ##1 !inj_q.terminalFramingFaultInject;
  endproperty
  a_ftOnce: assert property (p_ftOnce) else $error("framing pulse wrong"); // RL3
  property p_payOnce;
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(errIns_q[EI_PAY]) |=> inj_q.payloadFaultInject
      ##1 !inj_q.payloadFaultInject;
  endproperty
  a_payOnce: assert property (p_payOnce) else $error("payload pulse wrong"); // RL6
  property p_pinSel;
    @(posedge clk_sys) disable iff (!rst_b)
    signalAbsentIndicatorPin == ($past(lineSignalAbsentStatus)
      || (!$past(errIns_q[EI_SEL]) && $past(evtIn.terminalSyncLoss)));
  endproperty
  a_pinSel: assert property (p_pinSel) else $error("indicator pin source wrong"); // RL8
  property p_clrHold;
    @(posedge clk_sys) disable iff (!rst_b)
    rstCtl_q[RC_CLR] |=> counterClearHold;
  endproperty
  a_clrHold: assert property (p_clrHold) else $error("counters not held clear"); // RL12
  property p_oofPause;
    @(posedge clk_sys) disable iff (!rst_b)
    (rstCtl_q[RC_OOF] && evtIn.terminalSyncLoss) |=> !violationCountEnable;
  endproperty
  a_oofPause: assert property (p_oofPause) else $error("violation count not paused"); // RL14
  property p_dblSet;
    @(posedge clk_sys) disable iff (!rst_b)
    (wrStb && regHit(hostAddr, ADDR_RST_CTL) && !swRst_q)
      |=> controllerClockDouble == $past(hostWrData[RC_DBL]);
  endproperty
  a_dblSet: assert property (p_dblSet) else $error("clock double level wrong"); // RL16
  property p_tfsChg;
    @(posedge clk_sys) disable iff (!rst_b)
    ($changed(evtIn.terminalSyncLoss) && mask_q[IM_TFS] && !rstCtl_q[RC_SPN] && !swRst_q)
      |=> pend_q[IM_TFS];
  endproperty
  a_tfsChg: assert property (p_tfsChg) else $error("sync loss change not pending"); // RL18
  property p_losChg;
    @(posedge clk_sys) disable iff (!rst_b)
    ($changed(lineSignalAbsentStatus) && mask_q[IM_LOS] && !rstCtl_q[RC_SPN] && !swRst_q)
      |=> pend_q[IM_LOS];
  endproperty
  a_losChg: assert property (p_losChg) else $error("signal loss change not pending"); // RL20
  property p_sefEvt;
    @(posedge clk_sys) disable iff (!rst_b)
    (evtIn.severeFramingEvt && mask_q[IM_SEF] && !rstCtl_q[RC_SPN] && !swRst_q)
      |=> pend_q[IM_SEF];
  endproperty
  a_sefEvt: assert property (p_sefEvt) else $error("severe framing not pending"); // RL21
endmodule : t1ec_regs
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the error insert, reset control and mask registers
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import t1ec_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst_b = 1'b0;
  logic       hostSel, hostWr, hostRd;
  logic [7:0] hostAddr, hostWrData, hostRdData, rdv;
  t1ec_evt_t  evtIn = '0;
  logic       esfMode = 1'b0;
  logic       rxBitValid = 1'b0;
  logic       rxBit = 1'b0;
  logic       oneSecondTick = 1'b0;
  t1ec_inj_t  injectPulse;
  logic [4:0] injV;
  logic       allZero, losStat, losPin, clrHold, cue, vce, dbl, irqOutB, irqOe;
  logic [7:0] injCnt [5] = '{default: 8'h00};
  logic [7:0] injExp [5] = '{8'h02, 8'h01, 8'h02, 8'h01, 8'h02};
  int         mp [7] = '{IM_RXS, IM_TXS, IM_SEF, IM_AIS, IM_BOM, IM_MFS, IM_TFS};
  int         numErrors = 0;
  int         testsRun = 0;

  always #12.5 clk_sys = ~clk_sys;

  t1ec_regs dut (.clk_sys(clk_sys), .rst_b(rst_b), .hostSel(hostSel), .hostWr(hostWr),
    .hostRd(hostRd), .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
    .evtIn(evtIn), .esfMode(esfMode), .rxBitValid(rxBitValid), .rxBit(rxBit),
    .oneSecondTick(oneSecondTick), .injectPulse(injectPulse), .forceAllZeroTransmit(allZero),
    .lineSignalAbsentStatus(losStat), .signalAbsentIndicatorPin(losPin),
    .counterClearHold(clrHold), .counterUpdateEnable(cue), .violationCountEnable(vce),
    .controllerClockDouble(dbl), .irqOutB(irqOutB), .irqOe(irqOe));
  t1ec_host_model host (.clk_sys(clk_sys), .hostSel(hostSel), .hostWr(hostWr),
    .hostRd(hostRd), .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData));

  // tally of injection pulses; a stuck pulse shows as an excess count
  assign injV = injectPulse;
  always @(posedge clk_sys) begin
    for (int i = 0; i < 5; i++) begin
      injCnt[i] <= injCnt[i] + {7'h00, injV[i]};
    end
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rdv);
    chk("readback", rdv, exp);
  endtask : rdChk

  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  // n received bits of one value, back to back
  task automatic rxRun(input int n, input logic v);
    repeat (n) begin
      @(posedge clk_sys);
      rxBitValid <= 1'b1;
      rxBit      <= v;
    end
    @(posedge clk_sys);
    rxBitValid <= 1'b0;
    #1;
  endtask : rxRun

  task automatic setEvt(input logic [6:0] v);
    @(posedge clk_sys);
    evtIn <= t1ec_evt_t'(v);
    settle();
  endtask : setEvt

  // one-cycle high on the chosen sources: two changes for level sources
  task automatic evtPulse(input logic [6:0] v);
    @(posedge clk_sys);
    evtIn <= t1ec_evt_t'(v);
    @(posedge clk_sys);
    evtIn <= '0;
    settle();
  endtask : evtPulse

  task automatic testDone;
    $display("comparisons %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : testDone

  // watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    numErrors++;
    testDone();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    settle();
    chk("cntEn", {6'h00, cue, vce}, 8'h03);
    rdChk(ADDR_ERR_INS, REG_RST_VAL);
    rdChk(ADDR_RST_CTL, REG_RST_VAL);
    rdChk(ADDR_INT_MSK0, REG_RST_VAL);
    rdChk(8'h1C, RD_UNMAPPED);
    host.wr(ADDR_ERR_INS, 8'h0B);
    chk("allZero", {7'h00, allZero}, 8'h01);
    host.wr(8'h1C, 8'hFF);
    rdChk(ADDR_ERR_INS, 8'h0B);
    host.wr(ADDR_RST_CTL, 8'h1D);
    chk("clrDbl", {5'h00, clrHold, dbl, cue}, 8'h06);
    rdChk(ADDR_RST_CTL, 8'h1D);
    @(posedge clk_sys);
    oneSecondTick <= 1'b1;
    @(posedge clk_sys);
    oneSecondTick <= 1'b0;
    rdv = 8'h00;
    repeat (3) begin
      #1;
      rdv = rdv + {7'h00, cue};
      @(posedge clk_sys);
    end
    chk("tickOnce", rdv, 8'h01);
    setEvt(7'h40);
    chk("paused", {7'h00, vce}, 8'h00);
    setEvt(7'h00);
    chk("resumed", {7'h00, vce}, 8'h01);
    host.wr(ADDR_RST_CTL, 8'h00);
    chk("released", {5'h00, clrHold, dbl, cue}, 8'h01);
    // injections in both framing modes, level and falling writes in between
    @(posedge clk_sys);
    esfMode <= 1'b1;
    host.wr(ADDR_ERR_INS, 8'hF4);
    host.wr(ADDR_ERR_INS, 8'hF4);
    host.wr(ADDR_ERR_INS, 8'h00);
    esfMode <= 1'b0;
    host.wr(ADDR_ERR_INS, 8'hF4);
    host.wr(ADDR_ERR_INS, 8'h02);
    for (int i = 0; i < 5; i++) begin
      chk("injCount", injCnt[i], injExp[i]);
    end
    // zero-run thresholds at both settings, boundary minus one first
    rxRun(31, 1'b0);
    chk("los31", {7'h00, losStat}, 8'h00);
    rxRun(1, 1'b0);
    chk("los32", {7'h00, losStat}, 8'h01);
    settle();
    chk("pinLos", {7'h00, losPin}, 8'h01);
    rxRun(1, 1'b1);
    host.wr(ADDR_ERR_INS, 8'h00);
    rxRun(191, 1'b0);
    chk("los191", {7'h00, losStat}, 8'h00);
    rxRun(1, 1'b0);
    chk("los192", {7'h00, losStat}, 8'h01);
    rxRun(1, 1'b1);
    setEvt(7'h40);
    chk("pinLof", {6'h00, losPin, vce}, 8'h03);
    host.wr(ADDR_ERR_INS, 8'h01);
    chk("pinLosOnly", {7'h00, losPin}, 8'h00);
    setEvt(7'h00);
    // each framer event source, first blocked by its mask bit, then let through
    for (int i = 0; i < 7; i++) begin
      host.wr(ADDR_INT_MSK0, ~(8'h01 << mp[i]));
      evtPulse(7'h01 << i);
      chk("masked", {7'h00, irqOe}, 8'h00);
      host.wr(ADDR_INT_MSK0, 8'h01 << mp[i]);
      evtPulse(7'h01 << i);
      chk("raised", {6'h00, irqOutB, irqOe}, 8'h01);
      host.wr(ADDR_RST_CTL, 8'h20);
      chk("acked", {7'h00, irqOe}, 8'h00);
    end
    rdChk(ADDR_RST_CTL, 8'h00);
    host.wr(ADDR_INT_MSK0, 8'h08);
    host.wr(ADDR_ERR_INS, 8'h03);
    rxRun(32, 1'b0);
    settle();
    chk("losIrq", {7'h00, irqOe}, 8'h01);
    rxRun(1, 1'b1);
    host.wr(ADDR_RST_CTL, 8'h20);
    // suspend drops events and floats a pending request
    host.wr(ADDR_INT_MSK0, 8'h01);
    host.wr(ADDR_RST_CTL, 8'h40);
    evtPulse(7'h01);
    chk("suspended", {7'h00, irqOe}, 8'h00);
    host.wr(ADDR_RST_CTL, 8'h00);
    chk("dropped", {7'h00, irqOe}, 8'h00);
    evtPulse(7'h01);
    chk("live", {7'h00, irqOe}, 8'h01);
    host.wr(ADDR_RST_CTL, 8'h40);
    chk("floated", {7'h00, irqOe}, 8'h00);
    // soft reset with a pending request and non-default settings
    host.wr(ADDR_RST_CTL, 8'h00);
    host.wr(ADDR_ERR_INS, 8'h0B);
    host.wr(ADDR_RST_CTL, 8'h80);
    chk("softRst", {6'h00, irqOe, allZero}, 8'h00);
    rdChk(ADDR_ERR_INS, REG_RST_VAL);
    rdChk(ADDR_RST_CTL, REG_RST_VAL);
    rdChk(ADDR_INT_MSK0, REG_RST_VAL);
    testDone();
  end
endmodule : testbench
`default_nettype wire
